// *** inc/adsq_params.svh ***
/*
 * timing counts, command codes, field positions and reset values for the
 * converter serial command sequencer. assumes a 25 MHz core clock.
 */
`ifndef ADSQ_PARAMS_SVH
`define ADSQ_PARAMS_SVH

// ------------------------------------------------------------------
// command bytes
// ------------------------------------------------------------------
`define ADSQ_CMD_RESET      8'h06
`define ADSQ_CMD_WRITE_CFG  8'h43
`define ADSQ_CMD_READ_CFG   8'h23
`define ADSQ_CMD_START      8'h08
`define ADSQ_CMD_SLEEP      8'h02
`define ADSQ_CMD_OP_MASK    8'hF0
`define ADSQ_CMD_WR_OP      8'h40
`define ADSQ_CMD_RD_OP      8'h20

// ------------------------------------------------------------------
// configuration reset values and field positions
// ------------------------------------------------------------------
`define ADSQ_CFG0_RST       8'h00
`define ADSQ_CFG1_RST       8'h00
`define ADSQ_CFG2_RST       8'h00
`define ADSQ_CFG3_RST       8'h00
`define ADSQ_MUX_HI         7
`define ADSQ_MUX_LO         4
`define ADSQ_GAIN_HI        3
`define ADSQ_GAIN_LO        1
`define ADSQ_BYPASS_BIT     0
`define ADSQ_CONT_BIT       2
`define ADSQ_RDYM_BIT       1
`define ADSQ_MUX_SHORTED    4'hE
`define ADSQ_GAIN_MAX_BYP   3'h2

// ------------------------------------------------------------------
// timing
// ------------------------------------------------------------------
`define ADSQ_CLK_NS         40
`define ADSQ_CONV_NS        51200
`define ADSQ_CONV_CYC       ((`ADSQ_CONV_NS + `ADSQ_CLK_NS - 1) / `ADSQ_CLK_NS)
`define ADSQ_RDY_LOW_CYC    8'h20

`endif

// *** inc/adsq_pkg.sv ***
/*
 * types shared by the converter serial sequencer.
 * assumes adsq_params.svh is compiled alongside.
 */
package adsq_pkg;
    typedef enum logic [1:0] {
        ADSQ_PWR_SLEEP = 2'b00,
        ADSQ_PWR_IDLE  = 2'b01,
        ADSQ_PWR_CONV  = 2'b11
    } adsq_pwr_t;

    typedef enum logic [2:0] {
        ADSQ_PH_CMD   = 3'b000,
        ADSQ_PH_WRCFG = 3'b001,
        ADSQ_PH_RDCFG = 3'b011,
        ADSQ_PH_DATA  = 3'b010,
        ADSQ_PH_DONE  = 3'b110
    } adsq_phase_t;
endpackage

// *** verif/adsq_host_model.sv ***
/*
 * host-side serial master model: select, clock and data in mode 1.
 * assumes the converter samples these pins with its own core clock.
 */
`timescale 1ns/10ps
`default_nettype none

module adsq_host_model #(
    parameter int HALF_NS  = 160,
    parameter int SETUP_NS = 200,
    parameter int HOLD_NS  = 200
) (
    output var logic  sclk_out,
    output var logic  cs_n_out,
    output var logic  din_out,
    input  wire logic dout_in
);
    initial begin
        sclk_out = 1'b0;
        cs_n_out = 1'b1;
        din_out  = 1'b0;
    end

    // ------------------------------------------------------------------
    // framing
    // ------------------------------------------------------------------
    task automatic select();
        #7;
        cs_n_out = 1'b0;
        #(SETUP_NS);
    endtask

    task automatic deselect();
        #(HOLD_NS);
        cs_n_out = 1'b1;
        din_out  = ~din_out;
    endtask

    // ------------------------------------------------------------------
    // bits and bytes
    // ------------------------------------------------------------------
    task automatic bit_x(input logic tx, output logic rx);
        sclk_out = 1'b1;
        din_out  = tx;
        #(HALF_NS);
        sclk_out = 1'b0;
        rx       = dout_in;
        #(HALF_NS);
    endtask

    task automatic byte_x(input logic [7:0] tx, output logic [7:0] rx);
        for (int i = 7; i >= 0; i--)
            bit_x(tx[i], rx[i]);
    endtask
endmodule // adsq_host_model
`default_nettype wire

// *** verif/testbench.sv ***
/*
 * self-checking bench for the converter serial sequencer.
 * assumes adsq_host_model plays the host and a 25 MHz core clock.
 */
`timescale 1ns/10ps
`default_nettype none
`include "adsq_params.svh"

`define CHK(what, exp, got) begin samples_checked++; if ((got) !== (exp)) begin \
    err_total++; $display("FAIL %s expected %h seen %h", what, exp, got); end end

module testbench;
    localparam int CONV = 800;
    logic        ref_clk_in, sys_rst_in, sclk, cs_n, din;
    logic [23:0] sample_data_in;
    logic        sample_ready_out, dout, oe, rdy_n, pd, conv, shorted, byp, rdym;
    logic [2:0]  gain;
    logic        clamp, dropped;
    int          err_total = 0;
    int          samples_checked = 0;
    logic [23:0] last_rx;
    logic        share_mode = 1'b0;

    adsq_core #(.CONV_CYC(CONV)) i_adsq_core (
        .ref_clk_in(ref_clk_in), .sys_rst_in(sys_rst_in), .link_sclk_in(sclk),
        .link_cs_n_in(cs_n), .link_din_in(din), .sample_data_in(sample_data_in),
        .sample_ready_out(sample_ready_out), .link_dout_out(dout),
        .link_dout_oe_out(oe), .result_ready_pin_n_out(rdy_n), .powered_down_out(pd),
        .converting_out(conv), .inputs_shorted_out(shorted),
        .amplifier_bypass_bit_out(byp), .ready_pin_mode_bit_out(rdym),
        .gain_code_out(gain), .gain_clamped_out(clamp), .result_dropped_out(dropped));

    adsq_host_model i_adsq_host_model (
        .sclk_out(sclk), .cs_n_out(cs_n), .din_out(din), .dout_in(dout));

    initial ref_clk_in = 1'b0;
    always #20 ref_clk_in = ~ref_clk_in;

    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------
    task automatic cyc(input int n);
        repeat (n) @(negedge ref_clk_in);
    endtask

    task automatic cfg_frame(input logic [7:0] cmd, input logic [31:0] tx,
                             output logic [31:0] rx);
        logic [7:0] r;
        i_adsq_host_model.select();
        i_adsq_host_model.byte_x(cmd, r);
        for (int k = 3; k >= 0; k--)
            i_adsq_host_model.byte_x(tx[k*8 +: 8], rx[k*8 +: 8]);
        i_adsq_host_model.deselect();
        cyc(6);
    endtask

    task automatic cmd_frame(input logic [7:0] cmd);
        logic [7:0] r;
        i_adsq_host_model.select();
        i_adsq_host_model.byte_x(cmd, r);
        i_adsq_host_model.deselect();
        cyc(6);
    endtask

    task automatic read_result(input logic [23:0] exp);
        logic [23:0] rx;
        i_adsq_host_model.select();
        `CHK("shared ready", share_mode, oe)
        for (int k = 2; k >= 0; k--)
            i_adsq_host_model.byte_x(8'h00, rx[k*8 +: 8]);
        i_adsq_host_model.deselect();
        cyc(6);
        last_rx = rx;
        `CHK("result", exp, rx)
        `CHK("dout enable idle", 1'b0, oe)
    endtask

    task automatic wait_ready(input int lim);
        int n;
        n = 0;
        while (rdy_n !== 1'b0 && n < lim) begin
            cyc(1);
            n++;
        end
        `CHK("ready fall", 1'b0, rdy_n)
    endtask

    // ------------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------------
    task automatic t_reset();
        `CHK("reset state", 12'h800, {rdy_n, oe, dout, conv, pd, shorted, byp, gain, clamp, rdym})
        $display("test reset done");
    endtask

    task automatic t_modes();
        logic [7:0]  c0 [3] = '{8'hEB, 8'h03, 8'h0E};
        logic [7:0]  c3 [3] = '{8'h02, 8'h00, 8'h00};
        logic [6:0]  ex [3] = '{7'b1101011, 7'b0100100, 7'b0011100};
        logic [31:0] rx;
        for (int k = 0; k < 3; k++) begin
            cfg_frame(`ADSQ_CMD_WRITE_CFG, {c0[k], 16'h0000, c3[k]}, rx);
            `CHK("mode outputs", ex[k], {shorted, byp, gain, clamp, rdym})
        end
        cmd_frame(`ADSQ_CMD_RESET);
        cyc(1283);
        `CHK("defaults after reset cmd", 8'h00, {conv, shorted, byp, gain, clamp, rdym})
        $display("test modes done");
    endtask

    task automatic t_config();
        logic [31:0] rx;
        logic        r;
        logic [7:0]  wr_cmd;
        wr_cmd = `ADSQ_CMD_WRITE_CFG;
        cfg_frame(`ADSQ_CMD_WRITE_CFG, 32'h08041000, rx);
        `CHK("gain and bypass", 4'h8, {gain, byp})
        i_adsq_host_model.select();
        for (int i = 7; i > 2; i--)
            i_adsq_host_model.bit_x(wr_cmd[i], r);
        i_adsq_host_model.deselect();
        cyc(6);
        cfg_frame(`ADSQ_CMD_READ_CFG, 32'h00000000, rx);
        `CHK("read back", 32'h08041000, rx)
        $display("test config done");
    endtask

    task automatic t_stream();
        sample_data_in = 24'hA5C3F1;
        cmd_frame(`ADSQ_CMD_START);
        `CHK("converting", 1'b1, conv)
        wait_ready(CONV + 200);
        `CHK("shared pin quiet", 1'b0, oe)
        sample_data_in = 24'h3C0F96;
        read_result(24'hA5C3F1);
        `CHK("ready released", 1'b1, rdy_n)
        wait_ready(CONV + 200);
        sample_data_in = 24'h817E01;
        read_result(24'h3C0F96);
        $display("test stream done");
    endtask

    task automatic t_fill_sleep();
        int n;
        n = 0;
        while (dropped !== 1'b1 && n < 4 * CONV) begin
            @(posedge ref_clk_in);
            #1;
            n++;
        end
        `CHK("drop pulse", 1'b1, dropped)
        cyc(1);
        `CHK("buffer full", 1'b0, sample_ready_out)
        read_result(24'h817E01);
        read_result(24'h817E01);
        `CHK("buffer drained", 1'b1, sample_ready_out)
        cmd_frame(`ADSQ_CMD_SLEEP);
        `CHK("sleep state", 2'b10, {pd, conv})
        cyc(2 * CONV);
        `CHK("no result asleep", 1'b1, rdy_n)
        $display("test fill and sleep done");
    endtask

    task automatic t_offset();
        logic [31:0]        rx;
        logic signed [24:0] sum;
        logic signed [23:0] ofs;
        share_mode = 1'b1;
        cfg_frame(`ADSQ_CMD_WRITE_CFG, 32'hE8040002, rx);
        `CHK("inputs shorted", 1'b1, shorted)
        sample_data_in = 24'hFFFFF0;
        cmd_frame(`ADSQ_CMD_START);
        wait_ready(CONV + 200);
        sample_data_in = 24'h000030;
        read_result(24'hFFFFF0);
        sum = $signed(last_rx);
        wait_ready(CONV + 200);
        sample_data_in = 24'h001010;
        read_result(24'h000030);
        sum = sum + $signed(last_rx);
        ofs = sum[24:1];  // signed mean of shorted readings
        share_mode = 1'b0;
        cfg_frame(`ADSQ_CMD_WRITE_CFG, 32'h08040000, rx);
        wait_ready(CONV + 200);
        read_result(24'h001010);
        `CHK("offset corrected", 24'h001000, last_rx - ofs)
        cmd_frame(`ADSQ_CMD_SLEEP);
        $display("test offset done");
    endtask

    // ------------------------------------------------------------------
    // run control
    // ------------------------------------------------------------------
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    initial begin
        #(40 * 30000);
        err_total++;
        tally_and_finish();
    end

    initial begin
        sys_rst_in     = 1'b1;
        sample_data_in = 24'h000000;
        cyc(16);
        sys_rst_in = 1'b0;
        cyc(2);
        t_reset();
        cyc(1250);
        t_modes();
        t_config();
        t_stream();
        t_fill_sleep();
        t_offset();
        tally_and_finish();
    end
endmodule // testbench
`default_nettype wire

// *** verilog/adsq_core.sv ***
/*
 * converter-side serial command decoder, configuration store and result
 * shifter. assumes the host drives the link pins; all pins are sampled by
 * ref_clk_in through two flip-flops, the serial clock being far slower.
 */
// Functional notes
// - link uses clock polarity 0, phase 1; clock idles low
// - device flags new result by falling edge on ready pin
// - command 06h resets converter to power-up defaults
// - command 43h stores four following bytes into configuration
// - example bytes give gain 16, continuous mode, 50/60 Hz filter
// - command 23h returns all configuration registers
// - command 08h starts converting; continuous mode keeps going
// - chip select high resets serial state, discards partial command
// - 24 clocks without command shift out the 24-bit result
// - command 02h stops conversion and enters power-down
// - input select 1110 shorts both inputs to mid-supply
// - with bypass only gains 1, 2, 4 are supported
// - ready mode bit 0: ready only on dedicated pin
// - data changes on rising edge, sampled on falling edge
`timescale 1ns/10ps
`default_nettype none
`include "adsq_params.svh"

module adsq_core #(
    parameter int CONV_CYC = `ADSQ_CONV_CYC
) (
    input  wire logic              ref_clk_in,
    input  wire logic              sys_rst_in,
    input  wire logic              link_sclk_in,
    input  wire logic              link_cs_n_in,
    input  wire logic              link_din_in,
    input  wire logic [23:0]       sample_data_in,
    output logic                   sample_ready_out,
    output logic                   link_dout_out,
    output logic                   link_dout_oe_out,
    output logic                   result_ready_pin_n_out,
    output logic                   powered_down_out,
    output logic                   converting_out,
    output logic                   inputs_shorted_out,
    output logic                   amplifier_bypass_bit_out,
    output logic                   ready_pin_mode_bit_out,
    output logic [2:0]             gain_code_out,
    output logic                   gain_clamped_out,
    output logic                   result_dropped_out
);
    import adsq_pkg::*;

    // ------------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------------
    logic [1:0] sclk_s_r, cs_s_r, din_s_r;
    logic       sclk_d_r;
    always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            sclk_s_r <= 2'h0;
            cs_s_r   <= 2'h3;
            din_s_r  <= 2'h0;
            sclk_d_r <= 1'b0;
        end else begin
            sclk_s_r <= {sclk_s_r[0], link_sclk_in};
            cs_s_r   <= {cs_s_r[0], link_cs_n_in};
            din_s_r  <= {din_s_r[0], link_din_in};
            sclk_d_r <= sclk_s_r[1];
        end
    end

    wire cs_n     = cs_s_r[1];
    wire sclk_q   = sclk_s_r[1];
    wire din_q    = din_s_r[1];
    wire sclk_ris = sclk_q & ~sclk_d_r & ~cs_n;  // launch edge
    wire sclk_fal = ~sclk_q & sclk_d_r & ~cs_n;  // capture edge

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    adsq_pwr_t   pwr_r;
    adsq_phase_t ph_r;
    logic [7:0]  cfg_r [4];
    logic [7:0]  rx_r;
    logic [2:0]  bit_r;
    logic [4:0]  cnt_r;       // bits shifted in current frame
    logic [1:0]  idx_r;       // config byte index
    logic [23:0] sh_r;
    logic        first_r;     // no clock yet in this frame
    logic [31:0] conv_r;
    logic        rdy_r;
    logic [7:0]  rdy_cnt_r;

    // two-entry result buffer
    logic [23:0] buf_r [2];
    logic        wp_r, rp_r;
    logic [1:0]  fill_r;
    wire         buf_full  = (fill_r == 2'h2);
    wire         buf_empty = (fill_r == 2'h0);
    wire         conv_done = (pwr_r == ADSQ_PWR_CONV) && (conv_r == 32'h0);
    wire         push      = conv_done & ~buf_full;
    assign sample_ready_out = ~buf_full;

    wire [7:0]  rx_nxt    = {rx_r[6:0], din_q};
    wire        byte_done = sclk_fal && (bit_r == 3'h7);
    wire [7:0]  cmd_op    = rx_nxt & `ADSQ_CMD_OP_MASK;
    wire        is_wr     = (cmd_op == `ADSQ_CMD_WR_OP);
    wire        is_rd     = (cmd_op == `ADSQ_CMD_RD_OP);
    wire        cmd_byte  = byte_done && (ph_r == ADSQ_PH_CMD);
    // first launch edge with data waiting and no command: readout
    wire        start_rd  = sclk_ris && first_r && ~buf_empty &&
                            (ph_r == ADSQ_PH_CMD);
    wire        pop       = start_rd;
    wire        do_reset  = cmd_byte && (rx_nxt == `ADSQ_CMD_RESET);

    // ------------------------------------------------------------------
    // serial command and data phases
    // ------------------------------------------------------------------
    always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            ph_r    <= ADSQ_PH_CMD;
            rx_r    <= 8'h00;
            bit_r   <= 3'h0;
            cnt_r   <= 5'h00;
            idx_r   <= 2'h0;
            sh_r    <= 24'h0;
            first_r <= 1'b1;
            link_dout_out <= 1'b0;
        end else if (cs_n) begin
            ph_r    <= ADSQ_PH_CMD;  // deselect drops partial work
            bit_r   <= 3'h0;
            cnt_r   <= 5'h00;
            first_r <= 1'b1;
            link_dout_out <= 1'b0;
        end else begin
            if (sclk_ris) begin
                first_r <= 1'b0;
                if (start_rd) begin
                    ph_r          <= ADSQ_PH_DATA;
                    link_dout_out <= buf_r[rp_r][23];  // msb first
                    sh_r          <= {buf_r[rp_r][22:0], 1'b0};
                end else if (ph_r == ADSQ_PH_DATA || ph_r == ADSQ_PH_RDCFG) begin
                    link_dout_out <= sh_r[23];  // shift on rising
                    sh_r          <= {sh_r[22:0], 1'b0};
                end
            end
            if (sclk_fal) begin
                rx_r  <= rx_nxt;
                bit_r <= bit_r + 3'h1;
                cnt_r <= cnt_r + 5'h01;
                if (ph_r == ADSQ_PH_DATA && cnt_r == 5'h17) begin
                    ph_r <= ADSQ_PH_DONE;  // 24 bits out
                end
            end
            if (cmd_byte) begin
                idx_r <= 2'h0;
                if (is_wr) begin
                    ph_r <= ADSQ_PH_WRCFG;
                end else if (is_rd) begin
                    ph_r <= ADSQ_PH_RDCFG;
                    sh_r <= {cfg_r[0], cfg_r[1], cfg_r[2]};
                end
            end else if (byte_done && ph_r == ADSQ_PH_WRCFG) begin
                idx_r <= idx_r + 2'h1;
                if (idx_r == 2'h3) begin
                    ph_r <= ADSQ_PH_CMD;
                end
            end else if (byte_done && ph_r == ADSQ_PH_RDCFG) begin
                idx_r <= idx_r + 2'h1;
                if (idx_r == 2'h2) begin
                    sh_r <= {cfg_r[3], 16'h0000};
                end
                if (idx_r == 2'h3) begin
                    ph_r <= ADSQ_PH_CMD;
                end
            end
        end
    end

    // ------------------------------------------------------------------
    // configuration store
    // ------------------------------------------------------------------
    wire wr_cfg = byte_done && (ph_r == ADSQ_PH_WRCFG) && ~cs_n;
    always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            cfg_r[0] <= `ADSQ_CFG0_RST;
            cfg_r[1] <= `ADSQ_CFG1_RST;
            cfg_r[2] <= `ADSQ_CFG2_RST;
            cfg_r[3] <= `ADSQ_CFG3_RST;
        end else if (do_reset && ~cs_n) begin
            cfg_r[0] <= `ADSQ_CFG0_RST;
            cfg_r[1] <= `ADSQ_CFG1_RST;
            cfg_r[2] <= `ADSQ_CFG2_RST;
            cfg_r[3] <= `ADSQ_CFG3_RST;
        end else if (wr_cfg) begin
            cfg_r[idx_r] <= rx_nxt;  // stored in order
        end
    end

    wire [2:0] gain_raw = cfg_r[0][`ADSQ_GAIN_HI:`ADSQ_GAIN_LO];
    wire       bypass   = cfg_r[0][`ADSQ_BYPASS_BIT];
    wire       clamp    = bypass && (gain_raw > `ADSQ_GAIN_MAX_BYP);
    assign amplifier_bypass_bit_out = bypass;
    assign gain_code_out    = clamp ? `ADSQ_GAIN_MAX_BYP : gain_raw;
    assign gain_clamped_out = clamp;
    assign inputs_shorted_out =
        (cfg_r[0][`ADSQ_MUX_HI:`ADSQ_MUX_LO] == `ADSQ_MUX_SHORTED);
    assign ready_pin_mode_bit_out = cfg_r[3][`ADSQ_RDYM_BIT];
    wire   cont_mode = cfg_r[1][`ADSQ_CONT_BIT];

    // ------------------------------------------------------------------
    // conversion control and result buffer
    // ------------------------------------------------------------------
    wire start_cmd = cmd_byte && (rx_nxt == `ADSQ_CMD_START) && ~cs_n;
    wire sleep_cmd = cmd_byte && (rx_nxt == `ADSQ_CMD_SLEEP) && ~cs_n;
    always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            pwr_r  <= ADSQ_PWR_IDLE;
            conv_r <= 32'h0;
        end else if (sleep_cmd) begin
            pwr_r <= ADSQ_PWR_SLEEP;
        end else if (do_reset && ~cs_n) begin
            pwr_r <= ADSQ_PWR_IDLE;
        end else if (start_cmd) begin
            pwr_r  <= ADSQ_PWR_CONV;
            conv_r <= CONV_CYC - 1;
        end else if (conv_done) begin
            conv_r <= CONV_CYC - 1;
            if (!cont_mode) begin
                pwr_r <= ADSQ_PWR_IDLE;  // single shot ends
            end
        end else if (pwr_r == ADSQ_PWR_CONV) begin
            conv_r <= conv_r - 32'h1;
        end
    end

    always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            wp_r   <= 1'b0;
            rp_r   <= 1'b0;
            fill_r <= 2'h0;
            result_dropped_out <= 1'b0;
        end else begin
            if (push) begin
                buf_r[wp_r] <= sample_data_in;
                wp_r <= ~wp_r;
            end
            if (pop) begin
                rp_r <= ~rp_r;
            end
            fill_r <= fill_r + {1'b0, push} - {1'b0, pop};
            result_dropped_out <= conv_done & buf_full;
        end
    end

    // ready pin falls with each new result, released once read
    always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            rdy_r     <= 1'b1;
            rdy_cnt_r <= 8'h00;
        end else if (push) begin
            rdy_r     <= 1'b0;
            rdy_cnt_r <= `ADSQ_RDY_LOW_CYC;
        end else if (pop || (buf_empty && rdy_cnt_r == 8'h00)) begin
            rdy_r <= 1'b1;
        end else if (rdy_cnt_r != 8'h00) begin
            rdy_cnt_r <= rdy_cnt_r - 8'h01;
        end
    end
    assign result_ready_pin_n_out = rdy_r;

    // shared pin shows ready only when mode bit set
    wire   share_rdy = ready_pin_mode_bit_out & ~rdy_r & (ph_r == ADSQ_PH_CMD);
    assign link_dout_oe_out = ~cs_n & (ph_r == ADSQ_PH_DATA || ph_r == ADSQ_PH_RDCFG
                              || ph_r == ADSQ_PH_DONE || share_rdy);
    assign powered_down_out = (pwr_r == ADSQ_PWR_SLEEP);
    assign converting_out   = (pwr_r == ADSQ_PWR_CONV);
    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    property p_reset_cfg;
        @(posedge ref_clk_in) disable iff (sys_rst_in)
        (do_reset && ~cs_n) |=> (cfg_r[0] == `ADSQ_CFG0_RST && !converting_out);
    endproperty
    a_reset_cfg: assert property (p_reset_cfg) else $error("reset cmd ignored");
    property p_wr_cfg;
        @(posedge ref_clk_in) disable iff (sys_rst_in)
        (wr_cfg && idx_r == 2'h1) |=> (cfg_r[1] == $past(rx_nxt));
    endproperty
    a_wr_cfg: assert property (p_wr_cfg) else $error("cfg byte not stored");
    property p_start;
        @(posedge ref_clk_in) disable iff (sys_rst_in)
        start_cmd |=> converting_out;
    endproperty
    a_start: assert property (p_start) else $error("start not taken");
    property p_sleep;
        @(posedge ref_clk_in) disable iff (sys_rst_in)
        sleep_cmd |=> powered_down_out && !converting_out;
    endproperty
    a_sleep: assert property (p_sleep) else $error("sleep not taken");
    property p_deselect;
        @(posedge ref_clk_in) disable iff (sys_rst_in)
        cs_n |=> (ph_r == ADSQ_PH_CMD && bit_r == 3'h0);
    endproperty
    a_deselect: assert property (p_deselect) else $error("partial not discarded");
    sequence s_push;
        push;
    endsequence
    property p_ready_fall;
        @(posedge ref_clk_in) disable iff (sys_rst_in)
        s_push |=> !result_ready_pin_n_out;
    endproperty
    a_ready_fall: assert property (p_ready_fall) else $error("ready did not fall");
    property p_gain_cap;
        @(posedge ref_clk_in) disable iff (sys_rst_in)
        (amplifier_bypass_bit_out && cfg_r[0][3:1] > 3'h2) |->
            (gain_clamped_out && gain_code_out == 3'h2);
    endproperty
    a_gain_cap: assert property (p_gain_cap) else $error("gain above 4 bypassed");
    property p_no_share;
        @(posedge ref_clk_in) disable iff (sys_rst_in)
        (!ready_pin_mode_bit_out && ph_r == ADSQ_PH_CMD) |-> !link_dout_oe_out;
    endproperty
    a_no_share: assert property (p_no_share) else $error("shared pin driven");
    property p_dout_rise;
        @(posedge ref_clk_in) disable iff (sys_rst_in)
        (!cs_n && !$past(cs_n) && $changed(link_dout_out)) |-> $past(sclk_ris);
    endproperty
    a_dout_rise: assert property (p_dout_rise) else $error("dout moved off edge");
    property p_shorted;
        @(posedge ref_clk_in) disable iff (sys_rst_in)
        (cfg_r[0][7:4] == 4'hE) |-> inputs_shorted_out;
    endproperty
    a_shorted: assert property (p_shorted) else $error("mux short missed");
endmodule // adsq_core
`default_nettype wire
